/* File: common/train_pkg.sv */
package train_pkg;

  // ---------------------------------------------------------------
  // Register map (AHB-Lite byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LAT = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_ERR = 8'h0C;

  localparam int CTRL_ALL_PINS_BIT = 0;
  localparam int CTRL_REPEAT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [4:0] LAT_RESET = 5'h06;
  localparam int ERR_EARLY_BIT = 0;
  localparam int ERR_FORBID_BIT = 1;

  // ---------------------------------------------------------------
  // Mode register decode
  // ---------------------------------------------------------------
  localparam logic [2:0] MR_SEL_ZERO = 3'h0;
  localparam logic [2:0] MR_SEL_ONE = 3'h1;
  localparam logic [2:0] MR_SEL_THREE = 3'h3;
  localparam int WL_EN_BIT = 7;
  localparam int QOFF_BIT = 12;
  localparam int PAT_EN_BIT = 2;
  localparam int OTF_BIT = 12;
  localparam int ORDER_BIT = 2;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_CHOP4 = 2'h2;
  localparam logic [1:0] LOC_PREDEF = 2'h0;
  localparam logic [7:0] PATTERN_PREDEF = 8'hAA;
  localparam logic [7:0] PATTERN_RESERVED = 8'h00;

  // ---------------------------------------------------------------
  // Timing, in link clock cycles
  // ---------------------------------------------------------------
  localparam logic [3:0] T_MOD_NCK = 4'hC;
  localparam logic [3:0] T_MRD_NCK = 4'h4;
  localparam logic [3:0] T_MRD_LIMIT = T_MOD_NCK - T_MRD_NCK;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] addr;
    logic odt;
  } link_cmd_type;

  typedef struct packed {
    logic [2:0] start;
    logic chop;
    logic [7:0] pattern;
  } burst_type;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_LEVEL = 2'b01,
    ST_LEVEL_EXIT = 2'b10,
    ST_PATTERN = 2'b11
  } mode_type;

endpackage

/* File: hw/bit_sync.sv */
`timescale 1ns/100ps
module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // bit_sync

/* File: hw/pattern_shifter.sv */
`timescale 1ns/100ps
module pattern_shifter (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic load,
  input wire train_pkg::burst_type burst,
  input wire logic beat_en,
  // Serial beat
  output logic bit_r,
  output logic drive_r
);
  import train_pkg::*;

  logic [7:0] pattern_r;
  logic [2:0] idx_r;
  logic [3:0] rem_r;

  // ---------------------------------------------------------------
  // One beat per link clock edge, beat 0 at the pattern LSB
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pattern_r <= 8'h00;
      idx_r <= 3'h0;
      rem_r <= 4'h0;
      bit_r <= 1'b0;
      drive_r <= 1'b0;
    end else if (load) begin
      pattern_r <= burst.pattern;
      idx_r <= burst.start;
      rem_r <= burst.chop ? 4'h4 : 4'h8;
    end else if (beat_en) begin
      if (rem_r != 4'h0) begin
        bit_r <= pattern_r[idx_r]; // R21
        drive_r <= 1'b1;
        idx_r <= idx_r + 3'h1;
        rem_r <= rem_r - 4'h1;
      end else begin
        bit_r <= 1'b0;
        drive_r <= 1'b0;
      end
    end
  end

endmodule // pattern_shifter

/* File: hw/train_core.sv */
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
// How it works
// R1: Leveling feedback on prime bit per lane or all pins; others held low.
// R2: Controller stops driving strobes after the last rising strobe edge.
// R3: After leveling ends, data pins stay driven, undefined, until tMOD elapses.
// R4: Controller drives termination pin low, meeting setup, and keeps it low.
// R5: Controller clears leveling enable only after termination is off.
// R6: Any command allowed after tMOD; another mode command after tMRD.
// R7: Mode register three bit A2 switches the pattern function on or off.
// R8: Controller idles and precharges all banks before enabling the pattern.
// R9: Reads in pattern mode come from the pattern register, chosen by location.
// R10: In pattern mode only reads and the disabling mode command are legal; the error flag lets any mode command pass.
// R11: Device reset still works while the pattern function is enabled.
// R12: Read with autoprecharge in pattern mode acts as a plain read.
// R13: With pattern disabled, reads and writes go to the array.
// R14: Bit 0 of each lane carries the pattern; bits 7:1 repeat or zero.
// R15: Pattern reads use column bits 1:0 as zero; other address bits ignored.
// R16: Column bit 2 picks chopped order: beats 0-3 or beats 4-7.
// R17: Pattern reads honour burst chop, fixed or on the fly by A12.
// R18: Pattern data comes out after the ordinary read latency.
// R19: Controller ensures the delay-locked loop is locked before pattern reads.
// R20: Location zero returns alternating 0,1 beats.
// R21: Beat 0 maps to the pattern LSB, beat 7 to its MSB.
// R22: Controller waits tMRD and tMOD after enabling before the first read.
// R23: Controller waits recovery time, then disables and waits tMRD and tMOD.
// R24: Reserved locations return data nobody may rely on.
// R25: Mode register one bit A7 enters and leaves write leveling.
module train_core (
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Memory link inputs
  input wire logic ck_pin,
  input wire logic dram_reset_n,
  input wire train_pkg::link_cmd_type link_cmd,
  input wire logic dqs_in,
  // Memory link outputs
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic dqs_out,
  output logic dqs_oe,
  output logic array_cmd
);
  import train_pkg::*;

  // ---------------------------------------------------------------
  // Synchronisers and link clock edges
  // ---------------------------------------------------------------
  logic ck_s;
  logic rst_n_s;
  logic dqs_s;
  link_cmd_type cmd_s;
  logic ck_d_r;
  logic dqs_d_r;
  logic ck_rise;
  logic dqs_rise;
  logic beat_en_r;

  bit_sync #(.W(25)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({ck_pin, dram_reset_n, dqs_in, link_cmd}),
    .q({ck_s, rst_n_s, dqs_s, cmd_s})
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_d_r <= 1'b0;
      dqs_d_r <= 1'b0;
      beat_en_r <= 1'b0;
    end else begin
      ck_d_r <= ck_s;
      dqs_d_r <= dqs_s;
      beat_en_r <= ck_s ^ ck_d_r;
    end
  end

  assign ck_rise = ck_s & ~ck_d_r;
  assign dqs_rise = dqs_s & ~dqs_d_r;

  // ---------------------------------------------------------------
  // Command decode, sampled at link clock rise
  // ---------------------------------------------------------------
  logic cmd_sel;
  logic is_mrs;
  logic is_read;
  logic is_write;
  logic is_nop;

  assign cmd_sel = ck_rise & ~cmd_s.cs_n;
  assign is_nop = cmd_s.ras_n & cmd_s.cas_n & cmd_s.we_n;
  assign is_mrs = cmd_sel & ~cmd_s.ras_n & ~cmd_s.cas_n & ~cmd_s.we_n;
  assign is_read = cmd_sel & cmd_s.ras_n & ~cmd_s.cas_n & cmd_s.we_n;
  assign is_write = cmd_sel & cmd_s.ras_n & ~cmd_s.cas_n & ~cmd_s.we_n;

  // ---------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------
  logic [1:0] bl_mode_r;
  logic wl_en_r;
  logic qoff_r;
  logic pat_en_r;
  logic [1:0] loc_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bl_mode_r <= BL_FIXED8;
      wl_en_r <= 1'b0;
      qoff_r <= 1'b0;
      pat_en_r <= 1'b0;
      loc_r <= LOC_PREDEF;
    end else if (!rst_n_s) begin
      bl_mode_r <= BL_FIXED8; // R11
      wl_en_r <= 1'b0;
      qoff_r <= 1'b0;
      pat_en_r <= 1'b0; // R11
      loc_r <= LOC_PREDEF;
    end else if (is_mrs) begin
      if (cmd_s.ba == MR_SEL_ZERO) begin
        bl_mode_r <= cmd_s.addr[1:0];
      end else if (cmd_s.ba == MR_SEL_ONE) begin
        wl_en_r <= cmd_s.addr[WL_EN_BIT]; // R25
        qoff_r <= cmd_s.addr[QOFF_BIT];
      end else if (cmd_s.ba == MR_SEL_THREE) begin
        pat_en_r <= cmd_s.addr[PAT_EN_BIT]; // R7
        loc_r <= cmd_s.addr[1:0]; // R9
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode command recovery counter
  // ---------------------------------------------------------------
  logic [3:0] mod_cnt_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_cnt_r <= 4'h0;
    end else if (!rst_n_s) begin
      mod_cnt_r <= 4'h0;
    end else if (is_mrs) begin
      mod_cnt_r <= T_MOD_NCK; // R6
    end else if (ck_rise && mod_cnt_r != 4'h0) begin
      mod_cnt_r <= mod_cnt_r - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Operating mode
  // ---------------------------------------------------------------
  mode_type state_r;
  mode_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_NORMAL: begin
        if (wl_en_r) begin
          state_nxt = ST_LEVEL; // R25
        end else if (pat_en_r) begin
          state_nxt = ST_PATTERN;
        end
      end
      ST_LEVEL: begin
        if (!wl_en_r) begin
          state_nxt = ST_LEVEL_EXIT;
        end
      end
      ST_LEVEL_EXIT: begin
        if (mod_cnt_r == 4'h0) begin
          state_nxt = ST_NORMAL; // R3
        end
      end
      ST_PATTERN: begin
        if (!pat_en_r) begin
          state_nxt = ST_NORMAL;
        end
      end
      default: state_nxt = ST_NORMAL;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_NORMAL;
    end else if (!rst_n_s) begin
      state_r <= ST_NORMAL; // R11
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Leveling feedback: clock level caught at strobe rise
  // ---------------------------------------------------------------
  logic fb_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fb_r <= 1'b0;
    end else if (state_r == ST_NORMAL) begin
      fb_r <= 1'b0;
    end else if (state_r == ST_LEVEL && dqs_rise) begin
      fb_r <= ck_s;
    end
  end

  // ---------------------------------------------------------------
  // Pattern read latency and burst setup
  // ---------------------------------------------------------------
  logic [1:0] ctrl_r;
  logic [4:0] lat_r;
  logic [4:0] lat_cnt_r;
  burst_type burst_r;
  burst_type burst_new;
  logic chop_new;
  logic sh_load;
  logic sh_bit;
  logic sh_drive;

  assign chop_new = (bl_mode_r == BL_CHOP4) ||
                    (bl_mode_r == BL_OTF && !cmd_s.addr[OTF_BIT]); // R17
  // Bank, A10 and upper column bits do not enter the burst
  assign burst_new.chop = chop_new; // R15
  assign burst_new.start = chop_new ? {cmd_s.addr[ORDER_BIT], 2'b00} : 3'h0; // R16
  assign burst_new.pattern = (loc_r == LOC_PREDEF) ? PATTERN_PREDEF
                                                   : PATTERN_RESERVED; // R20

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_cnt_r <= 5'h00;
      burst_r <= '0;
    end else if (!rst_n_s) begin
      lat_cnt_r <= 5'h00;
    end else if (is_read && pat_en_r && lat_cnt_r == 5'h00) begin
      lat_cnt_r <= lat_r; // R18
      burst_r <= burst_new; // R9
    end else if (ck_rise && lat_cnt_r != 5'h00) begin
      lat_cnt_r <= lat_cnt_r - 5'h01;
    end
  end

  assign sh_load = ck_rise && lat_cnt_r == 5'h01;

  pattern_shifter u_shift (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(sh_load),
    .burst(burst_r),
    .beat_en(beat_en_r),
    .bit_r(sh_bit),
    .drive_r(sh_drive)
  );

  // ---------------------------------------------------------------
  // Data pin drive
  // ---------------------------------------------------------------
  logic [15:0] pat_word;
  logic [15:0] lvl_word;

  genvar lane;
  generate
    for (lane = 0; lane < 2; lane++) begin : g_lane
      assign pat_word[lane*8 +: 8] = {{7{ctrl_r[CTRL_REPEAT_BIT] & sh_bit}}, sh_bit}; // R14
      assign lvl_word[lane*8 +: 8] = {{7{ctrl_r[CTRL_ALL_PINS_BIT] & fb_r}}, fb_r}; // R1
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe <= 1'b0;
    end else begin
      case (state_r)
        ST_LEVEL: begin
          dq_out <= lvl_word; // R1
          dq_oe <= 1'b1;
          dqs_oe <= 1'b0;
        end
        ST_LEVEL_EXIT: begin
          dq_oe <= 1'b1; // R3
          dqs_oe <= 1'b0;
        end
        ST_PATTERN: begin
          dq_out <= sh_drive ? pat_word : 16'h0000; // R9
          dq_oe <= sh_drive;
          dqs_out <= ck_s;
          dqs_oe <= sh_drive;
        end
        default: begin
          dq_out <= 16'h0000;
          dq_oe <= 1'b0;
          dqs_out <= 1'b0;
          dqs_oe <= 1'b0;
        end
      endcase
    end
  end

  // Array path sees reads and writes only with the pattern off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      array_cmd <= 1'b0;
    end else begin
      array_cmd <= (is_read | is_write) & ~pat_en_r & rst_n_s; // R13 R12
    end
  end

  // ---------------------------------------------------------------
  // Protocol error flags
  // ---------------------------------------------------------------
  logic [1:0] err_r;
  logic [1:0] err_set;
  logic [1:0] err_clr;
  logic bus_wr;

  // Counter still holds one at the rise that is exactly tMOD after the command, and T_MRD_LIMIT + 1 at the rise exactly tMRD after it
  assign err_set[ERR_EARLY_BIT] = is_mrs ? (mod_cnt_r > T_MRD_LIMIT + 4'h1)
                                         : (cmd_sel && !is_nop && mod_cnt_r > 4'h1); // R6
  assign err_set[ERR_FORBID_BIT] = pat_en_r && cmd_sel && !is_nop &&
                                   !is_read && !is_mrs; // R10

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_r <= 2'h0;
    end else begin
      err_r <= (err_r & ~err_clr) | err_set;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  logic [7:0] dph_addr_r;
  logic dph_wr_r;
  logic [31:0] rd_word;
  logic addr_ok;

  assign addr_ok = hsel && hready && htrans[1] && hsize == 3'h2;
  assign bus_wr = dph_wr_r;
  assign err_clr = (bus_wr && dph_addr_r == ADDR_ERR) ? hwdata[1:0] : 2'h0;

  always_comb begin
    if (haddr[7:0] == ADDR_CTRL) begin
      rd_word = {30'h0, ctrl_r};
    end else if (haddr[7:0] == ADDR_LAT) begin
      rd_word = {27'h0, lat_r};
    end else if (haddr[7:0] == ADDR_STAT) begin
      rd_word = {19'h0, lat_cnt_r[3:0], bl_mode_r, qoff_r, mod_cnt_r != 4'h0,
                 fb_r, loc_r, state_r};
    end else if (haddr[7:0] == ADDR_ERR) begin
      rd_word = {30'h0, err_r};
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_addr_r <= 8'h00;
      dph_wr_r <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dph_wr_r <= addr_ok && hwrite && haddr[31:8] == 24'h00_0000;
      dph_addr_r <= haddr[7:0];
      if (addr_ok && !hwrite && haddr[31:8] == 24'h00_0000) begin
        hrdata <= rd_word;
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
      lat_r <= LAT_RESET;
    end else if (bus_wr && dph_addr_r == ADDR_CTRL) begin
      ctrl_r <= hwdata[1:0];
    end else if (bus_wr && dph_addr_r == ADDR_LAT && hwdata[4:0] != 5'h00) begin
      lat_r <= hwdata[4:0];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence mrs_three_on;
    is_mrs && cmd_s.ba == MR_SEL_THREE && cmd_s.addr[PAT_EN_BIT] && rst_n_s;
  endsequence

  sequence pattern_read;
    is_read && pat_en_r && lat_cnt_r == 5'h00 && rst_n_s;
  endsequence

  lvl_single_pin_a: assert property ( // R1
    state_r == ST_LEVEL && !ctrl_r[CTRL_ALL_PINS_BIT]
      |=> dq_out[7:1] == 7'h00 && dq_out[15:9] == 7'h00)
    else $error("unused data pins not low in leveling");

  exit_hold_a: assert property ( // R3
    $rose(state_r == ST_LEVEL_EXIT) |=> dq_oe [*2])
    else $error("data pins released before tMOD");

  mod_wait_a: assert property ( // R6
    is_mrs && rst_n_s |=> mod_cnt_r == T_MOD_NCK ##1 mod_cnt_r != 4'h0 [*3])
    else $error("mode recovery count wrong");

  pat_enable_a: assert property ( // R7
    mrs_three_on |=> pat_en_r ##1 state_r == ST_PATTERN)
    else $error("pattern mode not entered");

  read_latency_a: assert property ( // R18
    pattern_read |=> lat_cnt_r == lat_r)
    else $error("read latency not loaded");

  ap_ignored_a: assert property ( // R12
    is_read && pat_en_r |=> !array_cmd)
    else $error("pattern read reached the array");

  normal_array_a: assert property ( // R13
    (is_read || is_write) && !pat_en_r && rst_n_s |=> array_cmd)
    else $error("array access missing");

  reset_clears_a: assert property ( // R11
    !rst_n_s |=> !pat_en_r && !wl_en_r ##1 state_r == ST_NORMAL)
    else $error("device reset ignored in pattern mode");

endmodule // train_core

/* File: verification/ctrl_model.sv */
`timescale 1ns/100ps
// --------
// Controller side of the memory link
// --------
module ctrl_model (
  // Link
  output logic ck_pin,
  output logic dram_reset_n,
  output train_pkg::link_cmd_type link_cmd,
  output logic dqs_in
);
  import train_pkg::*;
  realtime t_cmd;
  logic odt_lvl;

  // Free running clock, no row ever opened, so banks stay idle and the loop locked
  initial begin
    ck_pin = 1'h0;
    dram_reset_n = 1'h1;
    dqs_in = 1'h0;
    odt_lvl = 1'h0;
    link_cmd = {1'h1, 3'h7, 3'h0, 14'h0, 1'h0};
    #7;
    forever #100 ck_pin = ~ck_pin;
  end

  // Command stands one full period around its sampling rise, then deselect
  task automatic cmd(input logic [2:0] op, input logic [2:0] ba, input logic [13:0] a);
    @(negedge ck_pin);
    link_cmd <= {1'h0, op, ba, a, odt_lvl};
    @(posedge ck_pin);
    t_cmd = $realtime;
    @(negedge ck_pin);
    link_cmd <= {1'h1, 3'h7, ~ba, ~a, odt_lvl};
  endtask

  // One strobe rise while the clock is at the given level, then released
  task automatic strobe(input logic lvl);
    do @(ck_pin); while (ck_pin !== lvl);
    #40 dqs_in = 1'h1;
    #60 dqs_in = 1'h0;
  endtask

  task automatic set_odt(input logic v);
    @(negedge ck_pin);
    odt_lvl = v;
    link_cmd.odt <= v;
  endtask

  task automatic dev_reset;
    @(negedge ck_pin);
    dram_reset_n = 1'h0;
    repeat (2) @(negedge ck_pin);
    dram_reset_n = 1'h1;
  endtask
endmodule // ctrl_model

/* File: verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import train_pkg::*;
  // --------
  // Signals and instances
  // --------
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [15:0] dq_out;
  logic hreadyout, hresp, dq_oe, dqs_out, dqs_oe, array_cmd, ck_pin, dram_reset_n, dqs_in;
  link_cmd_type link_cmd;
  int fail_count = 0;
  int compares = 0;
  int arr_cnt = 0;
  int arr0;
  logic [31:0] rd, rnd;
  logic [1:0] ctrl_v;
  realtime lat_a, lat_b;

  always #12.5 hclk = ~hclk;
  always @(posedge hclk) if (array_cmd === 1'h1) arr_cnt++;

  train_core i_train_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ck_pin(ck_pin),
    .dram_reset_n(dram_reset_n), .link_cmd(link_cmd), .dqs_in(dqs_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .array_cmd(array_cmd));
  ctrl_model i_ctrl_model (.ck_pin(ck_pin), .dram_reset_n(dram_reset_n),
    .link_cmd(link_cmd), .dqs_in(dqs_in));

  // --------
  // Tasks
  // --------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
    check("okay", 32'h0, {31'h0, hresp});
    hsel <= 1'h0;
  endtask

  task automatic wait_ck(input int n);
    repeat (n) @(posedge ck_pin);
  endtask

  // Samples each beat in mid-beat; a beat lasts four system cycles
  task automatic burst(input int n, input int st, input bit chk, output realtime lat);
    int k;
    logic b;
    logic [7:0] ln;
    k = 0;
    while (dq_oe !== 1'h1 && k < 600) begin
      @(posedge hclk);
      k++;
    end
    lat = $realtime - i_ctrl_model.t_cmd;
    for (int j = 0; j < n; j++) begin
      repeat ((j == 0) ? 2 : 4) @(posedge hclk);
      b = PATTERN_PREDEF[st + j];
      ln = ctrl_v[CTRL_REPEAT_BIT] ? {8{b}} : {7'h0, b};
      check("beat drive", 32'h1, {31'h0, dq_oe});
      check("beat strobe", 32'h1, {31'h0, dqs_oe});
      if (chk) check("beat", {16'h0, ln, ln}, {16'h0, dq_out});
    end
    repeat (4) @(posedge hclk);
    check("burst end", 32'h0, {30'h0, dq_oe, dqs_oe});
  endtask

  // --------
  // Main sequence
  // --------
  initial begin
    #1_000_000;
    fail_count++;
    complete_run;
  end

  initial begin
    rd = $urandom(32'h4488fc58);
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    ahb(1'h0, ADDR_CTRL, 32'h0, rd);
    check("ctrl reset", {30'h0, CTRL_RESET}, rd);
    ahb(1'h0, 32'h100, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    ahb(1'h1, ADDR_LAT, 32'h0, rd);
    ahb(1'h0, ADDR_LAT, 32'h0, rd);
    check("lat", {27'h0, LAT_RESET}, rd);
    ahb(1'h1, ADDR_LAT, 32'h2, rd);
    i_ctrl_model.cmd(3'h0, 3'h1, 14'h0080);
    wait_ck(12);
    ahb(1'h0, ADDR_STAT, 32'h0, rd);
    check("level state", 32'h1, rd & 32'h3);
    i_ctrl_model.set_odt(1'h1);
    for (int m = 0; m < 4; m++) begin
      ahb(1'h1, ADDR_CTRL, {31'h0, m[1]}, rd);
      i_ctrl_model.strobe(m[0]);
      wait_ck(2);
      check("feedback", m[0] ? (m[1] ? 32'hFFFF : 32'h0101) : 32'h0, {16'h0, dq_out});
    end
    i_ctrl_model.set_odt(1'h0);
    wait_ck(2);
    i_ctrl_model.cmd(3'h0, 3'h1, 14'h0);
    wait_ck(4);
    check("exit drive", 32'h1, {31'h0, dq_oe});
    wait_ck(10);
    check("exit release", 32'h0, {31'h0, dq_oe});
    i_ctrl_model.cmd(3'h0, 3'h0, 14'h0001);
    wait_ck(2);
    i_ctrl_model.cmd(3'h0, 3'h0, 14'h0001);
    wait_ck(12);
    ahb(1'h0, ADDR_ERR, 32'h0, rd);
    check("early", 32'h1, rd & 32'h3);
    ahb(1'h1, ADDR_ERR, 32'h1, rd);
    ahb(1'h0, ADDR_ERR, 32'h0, rd);
    check("err clear", 32'h0, rd);
    i_ctrl_model.cmd(3'h0, 3'h0, 14'h0001);
    wait_ck(3);
    i_ctrl_model.cmd(3'h0, 3'h0, 14'h0001);
    wait_ck(11);
    i_ctrl_model.cmd(3'h5, 3'h0, 14'h1000);
    wait_ck(2);
    ahb(1'h0, ADDR_ERR, 32'h0, rd);
    check("spacing", 32'h0, rd & 32'h3);
    ctrl_v = {1'($urandom_range(1)), 1'h0};
    ahb(1'h1, ADDR_CTRL, {30'h0, ctrl_v}, rd);
    arr0 = arr_cnt;
    for (int loc = 0; loc < 4; loc++) begin
      i_ctrl_model.cmd(3'h0, 3'h3, {11'h0, 1'h1, loc[1:0]});
      wait_ck(12);
      ahb(1'h0, ADDR_STAT, 32'h0, rd);
      check("pattern state", {28'h0, loc[1:0], 2'h3}, rd & 32'hF);
      for (int v = 0; v < 4; v++) begin
        rnd = $urandom;
        i_ctrl_model.cmd(3'h5, rnd[2:0],
          {rnd[3], v[0] == v[1], rnd[4], v == 3, rnd[11:5], v == 2, 2'h0});
        burst((v == 1 || v == 2) ? 4 : 8, (v == 2) ? 4 : 0, loc == 0, lat_b);
        if (loc == 0 && v == 0) lat_a = lat_b;
        wait_ck(4);
      end
    end
    check("array idle", arr0, arr_cnt);
    ahb(1'h1, ADDR_LAT, 32'h5, rd);
    i_ctrl_model.cmd(3'h5, 3'h0, 14'h1000);
    burst(8, 0, 1'h0, lat_b);
    check("latency step", 32'h258, 32'(int'(lat_b - lat_a)));
    wait_ck(4);
    i_ctrl_model.cmd(3'h4, 3'h0, 14'h0);
    wait_ck(2);
    ahb(1'h0, ADDR_ERR, 32'h0, rd);
    check("forbidden", 32'h2, rd & 32'h3);
    i_ctrl_model.dev_reset;
    wait_ck(2);
    ahb(1'h0, ADDR_STAT, 32'h0, rd);
    check("reset state", 32'h0, rd & 32'hF);
    i_ctrl_model.cmd(3'h0, 3'h3, 14'h0004);
    wait_ck(12);
    i_ctrl_model.cmd(3'h0, 3'h3, 14'h0003);
    wait_ck(12);
    arr0 = arr_cnt;
    i_ctrl_model.cmd(3'h5, 3'h0, 14'h1000);
    wait_ck(12);
    i_ctrl_model.cmd(3'h4, 3'h0, 14'h0);
    wait_ck(12);
    check("array access", arr0 + 2, arr_cnt);
    check("no drive", 32'h0, {29'h0, dq_oe, dqs_oe, dqs_out});
    complete_run;
  end
endmodule // testbench
